// ==== common/pprm_pkg.sv ====
/*
 * Shared constants for the port pin redirect mux: pin indices, redirect
 * field positions, variant field masks and reset values.
 * Assumes one flat pin vector ordered port 0, 2, 4, 12, 13.
 */
`default_nettype none

package pprm_pkg;

	localparam int NPINS = 18;

	typedef logic [4:0] pprm_pin_t;

	// flat pin vector positions
	localparam pprm_pin_t PIN_P00  = 5'h00;
	localparam pprm_pin_t PIN_P01  = 5'h01;
	localparam pprm_pin_t PIN_P02  = 5'h02;
	localparam pprm_pin_t PIN_P03  = 5'h03;
	localparam pprm_pin_t PIN_P04  = 5'h04;
	localparam pprm_pin_t PIN_P05  = 5'h05;
	localparam pprm_pin_t PIN_P06  = 5'h06;
	localparam pprm_pin_t PIN_P07  = 5'h07;
	localparam pprm_pin_t PIN_P20  = 5'h08;
	localparam pprm_pin_t PIN_P21  = 5'h09;
	localparam pprm_pin_t PIN_P22  = 5'h0A;
	localparam pprm_pin_t PIN_P23  = 5'h0B;
	localparam pprm_pin_t PIN_P40  = 5'h0C;
	localparam pprm_pin_t PIN_P41  = 5'h0D;
	localparam pprm_pin_t PIN_P121 = 5'h0E;
	localparam pprm_pin_t PIN_P122 = 5'h0F;
	localparam pprm_pin_t PIN_P125 = 5'h10;
	localparam pprm_pin_t PIN_P137 = 5'h11;
	localparam pprm_pin_t PIN_NONE = 5'h12;

	// ports 0, 2 and 4 carry an open-drain select
	localparam logic [17:0] OD_PRESENT = 18'h03FFF;

	localparam logic [17:0] LATCH_RST = 18'h00000;
	localparam logic [7:0]  REDIR_RST = 8'h00;

	localparam int REDIR_A = 0;
	localparam int REDIR_B = 1;
	localparam int REDIR_C = 2;
	localparam int REDIR_D = 3;

	// field positions (low bit of each field)
	localparam int T0_LOC  = 0;
	localparam int T1_LOC  = 2;
	localparam int T2_LOC  = 4;
	localparam int T3_LOC  = 6;
	localparam int S0_LOC  = 0;
	localparam int S1_LOC  = 2;
	localparam int I2C_LOC = 4;
	localparam int INT6_LOC = 6;
	localparam int BUZ_LOC = 0;
	localparam int CMP0_LOC = 2;

	localparam logic [1:0] LOC_PROHIBITED = 2'h3;

	// implemented redirect bits per package variant
	localparam logic [31:0] MASK_V8  = 32'h04000005;
	localparam logic [31:0] MASK_V10 = 32'h0500000D;
	localparam logic [31:0] MASK_V16 = 32'h175E177D;
	localparam logic [31:0] MASK_V20 = 32'h3FFF1FFF;

	typedef enum logic [1:0] {
		PPRM_RMW_AND,
		PPRM_RMW_OR,
		PPRM_RMW_XOR
	} pprm_rmw_op_t;

endpackage

`default_nettype wire

// ==== design/pprm_pin_cell.sv ====
/*
 * One pin's output combiner and buffer enable.
 * Assumes the caller already ties missing serial terms to 1 and missing
 * non-serial terms to 0.
 */
`timescale 1ns/1ns
`default_nettype none

module pprm_pin_cell #(
	parameter bit HAS_OD = 1'b1
) (
	// port side
	input  wire logic port_latch,
	input  wire logic dir_input,
	input  wire logic analog_sel,
	input  wire logic open_drain,
	// alternate functions
	input  wire logic ser_and,
	input  wire logic alt_or,
	// pin
	output logic      pin_out,
	output logic      pin_oe
);

	logic drive_val;
	logic od_eff;
	logic buf_on;

	assign drive_val = (port_latch & ser_and) | alt_or;
	assign od_eff    = HAS_OD ? open_drain : 1'b0;
	// analog use or input mode keeps the buffer off
	assign buf_on    = ~dir_input & ~analog_sel;
	assign pin_out   = drive_val;
	// open drain only pulls low
	assign pin_oe    = buf_on & (~od_eff | ~drive_val);

endmodule

`default_nettype wire

// ==== design/pprm_top.sv ====
/*
 * Port latches, read/write/read-modify-write paths, redirect controls and
 * pin routing of the alternate functions.
 * Assumes peripherals present their drive levels on this clock and that
 * pins arrive asynchronously.
 */
`timescale 1ns/1ns
`default_nettype none

module pprm_top #(
	parameter int VARIANT = 20
) (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   arst_n,
	// cpu port access
	input  wire logic                   cpu_wr,
	input  wire logic                   cpu_rmw,
	input  wire logic                   cpu_rd,
	input  wire pprm_pkg::pprm_rmw_op_t cpu_rmw_op,
	input  wire logic [17:0]            cpu_mask,
	input  wire logic [17:0]            cpu_wdata,
	output logic [17:0]                 cpu_rd_data,
	output logic [17:0]                 port_latch,
	// port mode
	input  wire logic [17:0]            port_dir_in,
	input  wire logic [17:0]            open_drain_select,
	input  wire logic [7:0]             analog_select_port0,
	input  wire logic [3:0]             analog_select_port2,
	// redirect controls
	input  wire logic [3:0]             redir_wr,
	input  wire logic [7:0]             redir_wdata,
	output logic [7:0]                  redirect_ctrl_a,
	output logic [7:0]                  redirect_ctrl_b,
	output logic [7:0]                  redirect_ctrl_c,
	output logic [7:0]                  redirect_ctrl_d,
	// pins
	input  wire logic [17:0]            pin_in,
	output logic [17:0]                 pin_out,
	output logic [17:0]                 pin_oe,
	// serial unit drive levels
	input  wire logic                   serial0_clock_drv,
	input  wire logic                   serial0_sda_drv,
	input  wire logic                   serial0_data_out,
	input  wire logic                   serial1_clock_drv,
	input  wire logic                   serial1_i2c_clock,
	input  wire logic                   serial1_i2c_data_drv,
	input  wire logic                   serial1_data_out,
	// other alternate drive levels
	input  wire logic                   timer0_output,
	input  wire logic                   timer1_io_drv,
	input  wire logic                   timer2_io_drv,
	input  wire logic                   timer3_output,
	input  wire logic                   i2c_clock_line_drv,
	input  wire logic                   i2c_data_line_drv,
	input  wire logic                   clock_buzzer_out,
	input  wire logic                   comparator0_out,
	// sensed pin levels to peripherals
	output logic                        serial0_clock_sense,
	output logic                        serial0_data_in,
	output logic                        serial1_clock_sense,
	output logic                        serial1_data_in,
	output logic                        serial1_i2c_data_sense,
	output logic                        timer0_input,
	output logic                        timer1_io_sense,
	output logic                        timer2_io_sense,
	output logic                        timer3_input,
	output logic                        i2c_clock_line_sense,
	output logic                        i2c_data_line_sense,
	output logic                        ext_interrupt6
);

	localparam int NP = pprm_pkg::NPINS;
	localparam bit HAS_BIG = (VARIANT >= 16);

	typedef struct packed {
		logic [NP-1:0]   latch;
		logic [3:0][7:0] redir;
		logic [NP-1:0]   sync1;
		logic [NP-1:0]   sync2;
		logic [NP-1:0]   rd_data;
	} pprm_state_t;

	pprm_state_t st_q;
	pprm_state_t st_d;

	function automatic logic [31:0] variant_mask(input int v);
		if (v == 8)
			return pprm_pkg::MASK_V8;
		else if (v == 10)
			return pprm_pkg::MASK_V10;
		else if (v == 16)
			return pprm_pkg::MASK_V16;
		return pprm_pkg::MASK_V20;
	endfunction

	localparam logic [31:0] REDIR_MASK = variant_mask(VARIANT);

	// prohibited code leaves the function unrouted
	function automatic pprm_pkg::pprm_pin_t loc3(input logic [1:0] code, input pprm_pkg::pprm_pin_t p0,
		input pprm_pkg::pprm_pin_t p1, input pprm_pkg::pprm_pin_t p2);
		case (code)
			2'h0: return p0;
			2'h1: return p1;
			2'h2: return p2;
			default: return pprm_pkg::PIN_NONE;
		endcase
	endfunction

	function automatic pprm_pkg::pprm_pin_t loc4(input logic [1:0] code, input pprm_pkg::pprm_pin_t p0,
		input pprm_pkg::pprm_pin_t p1, input pprm_pkg::pprm_pin_t p2, input pprm_pkg::pprm_pin_t p3);
		return (code == pprm_pkg::LOC_PROHIBITED) ? p3 : loc3(code, p0, p1, p2);
	endfunction

	function automatic logic [NP-1:0] onehot(input pprm_pkg::pprm_pin_t p);
		return (p < pprm_pkg::PIN_NONE) ? (18'h00001 << p) : 18'h00000;
	endfunction

	function automatic logic pick(input logic [NP-1:0] v, input pprm_pkg::pprm_pin_t p);
		return |(v & onehot(p));
	endfunction

	// function absent on this variant: no pin at all
	function automatic pprm_pkg::pprm_pin_t gate(input bit present, input pprm_pkg::pprm_pin_t p);
		return present ? p : pprm_pkg::PIN_NONE;
	endfunction

	logic [7:0]    ra, rb, rc, rd;
	logic [NP-1:0] analog_mask;
	logic [NP-1:0] pin_level;
	logic [NP-1:0] rd_val;
	logic [NP-1:0] rmw_res;
	logic [NP-1:0] ser_and;
	logic [NP-1:0] alt_or;

	pprm_pkg::pprm_pin_t t0i_pin, t0o_pin, t1_pin, t2_pin, t3i_pin, t3o_pin;
	pprm_pkg::pprm_pin_t s0c_pin, s0d_pin, s0o_pin;
	pprm_pkg::pprm_pin_t s1c_pin, s1l_pin, s1i_pin, s1a_pin, s1o_pin;
	pprm_pkg::pprm_pin_t icl_pin, ida_pin, int6_pin, buz_pin, cmp_pin;

	assign ra = st_q.redir[pprm_pkg::REDIR_A];
	assign rb = st_q.redir[pprm_pkg::REDIR_B];
	assign rc = st_q.redir[pprm_pkg::REDIR_C];
	assign rd = st_q.redir[pprm_pkg::REDIR_D];

	// P00 has no analog path; ports 4, 12, 13 are digital only
	assign analog_mask = {6'h00, analog_select_port2, analog_select_port0[7:1], 1'b0};
	assign pin_level   = st_q.sync2 & ~analog_mask;

	// timers
	assign t0i_pin = loc3(ra[pprm_pkg::T0_LOC +: 2], pprm_pkg::PIN_P137, pprm_pkg::PIN_P03,
		pprm_pkg::PIN_P20);
	assign t0o_pin = loc3(ra[pprm_pkg::T0_LOC +: 2], pprm_pkg::PIN_P03, pprm_pkg::PIN_P03,
		pprm_pkg::PIN_P21);
	assign t1_pin  = loc3(ra[pprm_pkg::T1_LOC +: 2], pprm_pkg::PIN_P04, pprm_pkg::PIN_P40,
		pprm_pkg::PIN_P02);
	assign t2_pin  = gate(HAS_BIG, loc3(ra[pprm_pkg::T2_LOC +: 2], pprm_pkg::PIN_P05, pprm_pkg::PIN_P01,
		pprm_pkg::PIN_P41));
	assign t3i_pin = gate(HAS_BIG, loc3(ra[pprm_pkg::T3_LOC +: 2], pprm_pkg::PIN_P41, pprm_pkg::PIN_P41,
		pprm_pkg::PIN_P20));
	assign t3o_pin = gate(HAS_BIG, loc3(ra[pprm_pkg::T3_LOC +: 2], pprm_pkg::PIN_P41, pprm_pkg::PIN_P07,
		pprm_pkg::PIN_P20));

	// serial channel 0
	assign s0c_pin = loc3(rb[pprm_pkg::S0_LOC +: 2], pprm_pkg::PIN_P02, pprm_pkg::PIN_P06,
		pprm_pkg::PIN_P05);
	assign s0d_pin = loc3(rb[pprm_pkg::S0_LOC +: 2], pprm_pkg::PIN_P01, pprm_pkg::PIN_P05,
		pprm_pkg::PIN_P04);
	assign s0o_pin = loc3(rb[pprm_pkg::S0_LOC +: 2], pprm_pkg::PIN_P00, pprm_pkg::PIN_P04,
		pprm_pkg::PIN_P03);

	// serial channel 1, code 11 splits clock and data lines
	assign s1c_pin = gate(HAS_BIG, loc4(rb[pprm_pkg::S1_LOC +: 2], pprm_pkg::PIN_P07, pprm_pkg::PIN_P00,
		pprm_pkg::PIN_P20, pprm_pkg::PIN_P07));
	assign s1l_pin = gate(HAS_BIG, loc4(rb[pprm_pkg::S1_LOC +: 2], pprm_pkg::PIN_P07, pprm_pkg::PIN_P00,
		pprm_pkg::PIN_P20, pprm_pkg::PIN_P23));
	assign s1i_pin = gate(HAS_BIG, loc4(rb[pprm_pkg::S1_LOC +: 2], pprm_pkg::PIN_P06, pprm_pkg::PIN_P01,
		pprm_pkg::PIN_P125, pprm_pkg::PIN_P06));
	assign s1a_pin = gate(HAS_BIG, loc4(rb[pprm_pkg::S1_LOC +: 2], pprm_pkg::PIN_P06, pprm_pkg::PIN_P01,
		pprm_pkg::PIN_P41, pprm_pkg::PIN_P22));
	assign s1o_pin = gate(HAS_BIG, loc4(rb[pprm_pkg::S1_LOC +: 2], pprm_pkg::PIN_P05, pprm_pkg::PIN_P02,
		pprm_pkg::PIN_P41, pprm_pkg::PIN_P05));

	// i2c unit, interrupt 6, buzzer, comparator
	assign icl_pin  = gate(HAS_BIG, rb[pprm_pkg::I2C_LOC] ? pprm_pkg::PIN_P00 : pprm_pkg::PIN_P06);
	assign ida_pin  = gate(HAS_BIG, rb[pprm_pkg::I2C_LOC] ? pprm_pkg::PIN_P01 : pprm_pkg::PIN_P07);
	assign int6_pin = loc3(rc[pprm_pkg::INT6_LOC +: 2], pprm_pkg::PIN_P00, pprm_pkg::PIN_P05,
		pprm_pkg::PIN_P23);
	assign buz_pin  = loc3(rd[pprm_pkg::BUZ_LOC +: 2], pprm_pkg::PIN_P02, pprm_pkg::PIN_P40,
		pprm_pkg::PIN_P06);
	assign cmp_pin  = rd[pprm_pkg::CMP0_LOC] ? pprm_pkg::PIN_P125 :
		((VARIANT == 8) ? pprm_pkg::PIN_P40 : pprm_pkg::PIN_P02);

	// pins without a serial output see 1, without another output see 0
	assign ser_and = ~(({NP{~serial0_clock_drv}} & onehot(s0c_pin))
		| ({NP{~serial0_sda_drv}} & onehot(s0d_pin))
		| ({NP{~serial0_data_out}} & onehot(s0o_pin))
		| ({NP{~serial1_clock_drv}} & onehot(s1c_pin))
		| ({NP{~serial1_i2c_clock}} & onehot(s1l_pin))
		| ({NP{~serial1_i2c_data_drv}} & onehot(s1a_pin))
		| ({NP{~serial1_data_out}} & onehot(s1o_pin)));
	assign alt_or = ({NP{timer0_output}} & onehot(t0o_pin))
		| ({NP{timer1_io_drv}} & onehot(t1_pin))
		| ({NP{timer2_io_drv}} & onehot(t2_pin))
		| ({NP{timer3_output}} & onehot(t3o_pin))
		| ({NP{i2c_clock_line_drv}} & onehot(icl_pin))
		| ({NP{i2c_data_line_drv}} & onehot(ida_pin))
		| ({NP{clock_buzzer_out}} & onehot(buz_pin))
		| ({NP{comparator0_out}} & onehot(cmp_pin));

	// sensed levels; an unrouted function sees low
	assign serial0_clock_sense    = pick(pin_level, s0c_pin);
	assign serial0_data_in        = pick(pin_level, s0d_pin);
	assign serial1_clock_sense    = pick(pin_level, s1c_pin);
	assign serial1_data_in        = pick(pin_level, s1i_pin);
	assign serial1_i2c_data_sense = pick(pin_level, s1a_pin);
	assign timer0_input           = pick(pin_level, t0i_pin);
	assign timer1_io_sense        = pick(pin_level, t1_pin);
	assign timer2_io_sense        = pick(pin_level, t2_pin);
	assign timer3_input           = pick(pin_level, t3i_pin);
	assign i2c_clock_line_sense   = pick(pin_level, icl_pin);
	assign i2c_data_line_sense    = pick(pin_level, ida_pin);
	assign ext_interrupt6         = pick(pin_level, int6_pin);

	// input bits read the pin, output bits read the latch
	assign rd_val = (port_dir_in & pin_level) | (~port_dir_in & st_q.latch);

	always_comb begin
		unique case (cpu_rmw_op)
			pprm_pkg::PPRM_RMW_AND: rmw_res = rd_val & cpu_wdata;
			pprm_pkg::PPRM_RMW_OR:  rmw_res = rd_val | cpu_wdata;
			pprm_pkg::PPRM_RMW_XOR: rmw_res = rd_val ^ cpu_wdata;
			default:                rmw_res = rd_val;
		endcase
	end

	always_comb begin
		st_d = st_q;
		st_d.sync1 = pin_in;
		st_d.sync2 = st_q.sync1;
		// a plain write wins over a read-modify-write in the same cycle
		if (cpu_wr) begin
			st_d.latch = (st_q.latch & ~cpu_mask) | (cpu_wdata & cpu_mask);
		end else if (cpu_rmw) begin
			st_d.latch = (st_q.latch & ~cpu_mask) | (rmw_res & cpu_mask);
		end
		if (cpu_rd) begin
			st_d.rd_data = rd_val;
		end
		// unimplemented bits are forced to their reset value
		for (int k = 0; k < 4; k++) begin
			if (redir_wr[k]) begin
				st_d.redir[k] = redir_wdata & REDIR_MASK[k*8 +: 8];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q.latch   <= pprm_pkg::LATCH_RST;
			st_q.redir   <= {4{pprm_pkg::REDIR_RST}};
			st_q.sync1   <= 18'h00000;
			st_q.sync2   <= 18'h00000;
			st_q.rd_data <= 18'h00000;
		end else begin
			st_q <= st_d;
		end
	end

	assign port_latch      = st_q.latch;
	assign cpu_rd_data     = st_q.rd_data;
	assign redirect_ctrl_a = ra;
	assign redirect_ctrl_b = rb;
	assign redirect_ctrl_c = rc;
	assign redirect_ctrl_d = rd;

	for (genvar i = 0; i < NP; i++) begin : g_pin
		pprm_pin_cell #(
			.HAS_OD (pprm_pkg::OD_PRESENT[i])
		) u_cell (
			.port_latch (st_q.latch[i]),
			.dir_input  (port_dir_in[i]),
			.analog_sel (analog_mask[i]),
			.open_drain (open_drain_select[i]),
			.ser_and    (ser_and[i]),
			.alt_or     (alt_or[i]),
			.pin_out    (pin_out[i]),
			.pin_oe     (pin_oe[i])
		);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_latch_write: assert property (cpu_wr |=> ((port_latch ^ $past(cpu_wdata)) & $past(cpu_mask)) == 18'h00000)
		else $error("latch missed a write");
	a_latch_hold: assert property (!cpu_wr && !cpu_rmw |=> port_latch == $past(port_latch))
		else $error("latch changed without a write");
	a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0) !arst_n |-> port_latch == 18'h00000)
		else $error("latch not cleared in reset");
	a_redir_reset: assert property (@(posedge sys_clk) disable iff (1'b0)
		!arst_n |-> {redirect_ctrl_a, redirect_ctrl_b, redirect_ctrl_c, redirect_ctrl_d} == 32'h00000000)
		else $error("redirect not cleared in reset");
	a_input_undriven: assert property ((pin_oe & port_dir_in) == 18'h00000)
		else $error("input pin is driven");
	a_read_output: assert property (cpu_rd |=> ((cpu_rd_data ^ $past(port_latch)) & ~$past(port_dir_in)) == 18'h00000)
		else $error("output read not from latch");
	a_read_input: assert property ($stable(pin_in) ##1 (cpu_rd && $stable(pin_in)) |=>
		((cpu_rd_data ^ ($past(pin_in) & ~$past(analog_mask))) & $past(port_dir_in)) == 18'h00000)
		else $error("input read not from pin");
	a_rmw_output: assert property (cpu_rmw && !cpu_wr && cpu_rmw_op == pprm_pkg::PPRM_RMW_XOR |=>
		((port_latch ^ $past(port_latch) ^ $past(cpu_wdata)) & $past(cpu_mask) & ~$past(port_dir_in)) == 18'h00000)
		else $error("output rmw wrong");
	a_rmw_input: assert property (cpu_rmw && !cpu_wr && cpu_rmw_op == pprm_pkg::PPRM_RMW_OR |=>
		((port_latch ^ ($past(pin_level) | $past(cpu_wdata))) & $past(cpu_mask) & $past(port_dir_in)) == 18'h00000)
		else $error("input rmw wrong");
	a_serial0_route: assert property (rb[1:0] == 2'h1 && !serial0_data_out && !port_dir_in[4] && !analog_mask[4]
		|-> !pin_out[4])
		else $error("serial0 output not on its pin");
	a_timer0_route: assert property (ra[1:0] == 2'h0 && timer0_output |-> pin_out[3] && !pin_out[17])
		else $error("timer0 output misrouted");
	a_prohibited_none: assert property (ra[1:0] == pprm_pkg::LOC_PROHIBITED |-> !timer0_input)
		else $error("prohibited code routed a pin");

	c_write_output: cover property (cpu_wr && port_dir_in == 18'h00000 ##1 pin_oe != 18'h00000);
	c_rmw_input: cover property (cpu_rmw && port_dir_in != 18'h00000);
	c_serial1_split: cover property (rb[3:2] == 2'h3 && serial1_i2c_clock == 1'b0);
	c_prohibited: cover property (ra[1:0] == pprm_pkg::LOC_PROHIBITED);

endmodule

`default_nettype wire

// ==== tb/pprm_pin_model.sv ====
/*
 * Outside pin circuitry: a pin follows the device while it drives.
 * Assumes the bench picks the outside level of undriven pins.
 */
`timescale 1ns/1ns
`default_nettype none
module pprm_pin_model (
	// device side
	input  wire logic [17:0] pin_out,
	input  wire logic [17:0] pin_oe,
	// outside
	input  wire logic [17:0] ext_level,
	output logic      [17:0] pin_level
);
	// released pins show outside level, never the stale drive
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ==== tb/pprm_top_bench.sv ====
/*
 * Random and directed bench for pprm_top, variant 20.
 * Assumes pprm_pin_model closes the pin loop.
 */
`timescale 1ns/1ns
`default_nettype none
module pprm_top_bench;
	logic                   clk, rst_n, wr, rmw, rd;
	pprm_pkg::pprm_rmw_op_t op;
	logic [17:0]            msk, wd, dir, od, ext, rdd, lat, pout, poe, pin, e_lat, v;
	logic [7:0]             an0, rwd, ra, rb, rc, rg, xd;
	logic [6:0]             sd;
	logic [3:0]             an2, rwr;
	logic [11:0]            sn;
	int                     bad_count, compares;
	int unsigned            seed = 10;
	pprm_top #(.VARIANT(20)) dut_u (.sys_clk(clk), .arst_n(rst_n), .cpu_wr(wr), .cpu_rmw(rmw),
		.cpu_rd(rd), .cpu_rmw_op(op), .cpu_mask(msk), .cpu_wdata(wd), .cpu_rd_data(rdd),
		.port_latch(lat), .port_dir_in(dir), .open_drain_select(od), .analog_select_port0(an0),
		.analog_select_port2(an2), .redir_wr(rwr), .redir_wdata(rwd), .redirect_ctrl_a(ra),
		.redirect_ctrl_b(rb), .redirect_ctrl_c(rc), .redirect_ctrl_d(rg), .pin_in(pin),
		.pin_out(pout), .pin_oe(poe), .serial0_clock_drv(sd[0]), .serial0_sda_drv(sd[1]),
		.serial0_data_out(sd[2]), .serial1_clock_drv(sd[3]), .serial1_i2c_clock(sd[4]),
		.serial1_i2c_data_drv(sd[5]), .serial1_data_out(sd[6]), .timer0_output(xd[0]),
		.timer1_io_drv(xd[1]), .timer2_io_drv(xd[2]), .timer3_output(xd[3]),
		.i2c_clock_line_drv(xd[4]), .i2c_data_line_drv(xd[5]), .clock_buzzer_out(xd[6]),
		.comparator0_out(xd[7]), .serial0_clock_sense(sn[0]), .serial0_data_in(sn[1]),
		.serial1_clock_sense(sn[2]), .serial1_data_in(sn[3]), .serial1_i2c_data_sense(sn[4]),
		.timer0_input(sn[5]), .timer1_io_sense(sn[6]), .timer2_io_sense(sn[7]),
		.timer3_input(sn[8]), .i2c_clock_line_sense(sn[9]), .i2c_data_line_sense(sn[10]),
		.ext_interrupt6(sn[11]));
	pprm_pin_model pm_u (.pin_out(pout), .pin_oe(poe), .ext_level(ext), .pin_level(pin));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [17:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[17:0];
	endfunction
	function automatic logic [17:0] opf(input pprm_pkg::pprm_rmw_op_t o, input logic [17:0] a, b);
		if (o == pprm_pkg::PPRM_RMW_AND) return a & b;
		if (o == pprm_pkg::PPRM_RMW_OR) return a | b;
		return a ^ b;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk(input string s, input logic [17:0] e, g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	task automatic rgw(input logic [3:0] k, input logic [7:0] d);
		rwr = k;
		rwd = d;
		cyc(1);
		rwr = 4'h0;
	endtask
	task automatic loc(input logic [3:0] k, input int sh, s, o, input int p[4]);
		logic [17:0] ev;
		dir = o ? 18'h00000 : 18'h3FFFF;
		for (int c = 0; c < 4; c++) begin
			rgw(k, 8'(c << sh));
			ev = (p[c] < 18) ? 18'h00001 << p[c] : 18'h00000;
			if (o) begin
				xd = 8'h01 << s;
				cyc(1);
				chk("pin_out", ev, pout);
				xd = 8'h00;
			end else begin
				ext = ev;
				cyc(3);
				chk("sense", {17'h0, ev != 0}, {17'h0, sn[s]});
				ext = ~ev;
				cyc(3);
				chk("sense", 18'h00000, {17'h0, sn[s]});
			end
		end
	endtask
	task automatic stop_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		{wr, rmw, rd, rst_n, msk, wd, dir, od, ext, rwr, rwd, xd, an2, e_lat} = '0;
		op = pprm_pkg::PPRM_RMW_AND;
		an0 = 8'h00;
		sd = 7'h7F;
		cyc(8);
		rst_n = 1'b1;
		chk("latch", 18'h00000, lat);
		chk("redir", 18'h00000, {ra, rb, rc[1:0]});
		for (int i = 0; i < 30; i++) begin
			dir = rnd();
			ext = rnd();
			msk = rnd();
			wd = rnd();
			wr = 1'b1;
			cyc(1);
			wr = 1'b0;
			e_lat = (e_lat & ~msk) | (wd & msk);
			cyc(2);
			chk("latch", e_lat, lat);
			chk("pin_out", e_lat & ~dir, pout & ~dir);
			chk("pin_oe", ~dir, poe);
			v = (dir & ext) | (~dir & e_lat);
			rd = 1'b1;
			cyc(1);
			rd = 1'b0;
			chk("rd_data", v, rdd);
			chk("latch", e_lat, lat);
			op = pprm_pkg::pprm_rmw_op_t'(2'(rnd() % 3));
			msk = rnd();
			wd = rnd();
			rmw = 1'b1;
			cyc(1);
			rmw = 1'b0;
			e_lat = (e_lat & ~msk) | (opf(op, v, wd) & msk);
			chk("latch", e_lat, lat);
			chk("pin_out", e_lat & ~dir, pout & ~dir);
			chk("pin_oe", ~dir, poe);
		end
		dir = 18'h00000;
		rgw(4'h2, 8'h10);
		for (int j = 0; j < 8; j++) begin
			msk = 18'h00001;
			wd = {17'h0, j[2]};
			wr = 1'b1;
			sd[2] = j[1];
			xd[4] = j[0];
			cyc(1);
			wr = 1'b0;
			chk("combiner", {17'h0, (j[2] & j[1]) | j[0]}, pout & 18'h00001);
		end
		{sd[2], xd, msk, wd, wr} = {1'b1, 8'h00, 18'h3FFFF, 18'h00000, 1'b1};
		cyc(1);
		wr = 1'b0;
		rgw(4'h1, 8'hFF);
		rgw(4'h2, 8'h1F);
		rgw(4'h4, 8'hFF);
		rgw(4'h8, 8'h3F);
		chk("redir", {2'h0, 8'hFF, 8'h1F}, {2'h0, ra, rb});
		chk("redir", {2'h0, 8'hFF, 8'h3F}, {2'h0, rc, rg});
		loc(4'h1, 0, 5, 0, '{17, 3, 8, 18});
		loc(4'h1, 2, 6, 0, '{4, 12, 2, 18});
		loc(4'h1, 4, 7, 0, '{5, 1, 13, 18});
		loc(4'h1, 6, 8, 0, '{13, 13, 8, 18});
		loc(4'h2, 0, 1, 0, '{1, 5, 4, 18});
		loc(4'h2, 2, 3, 0, '{6, 1, 16, 6});
		loc(4'h4, 6, 11, 0, '{0, 5, 11, 18});
		loc(4'h1, 6, 3, 1, '{13, 7, 8, 18});
		loc(4'h1, 0, 0, 1, '{3, 3, 9, 18});
		loc(4'h8, 0, 6, 1, '{2, 12, 6, 18});
		an0 = 8'hFE;
		cyc(1);
		chk("pin_oe", 18'h00000, poe & 18'h000FE);
		an0 = 8'h00;
		{msk, wd, wr} = {18'h3FFFF, 18'h2A5A5, 1'b1};
		od = 18'h3FFFF;
		cyc(1);
		wr = 1'b0;
		chk("pin_oe", 18'h3DA5A, poe);
		rgw(4'h1, 8'h55);
		rst_n = 1'b0;
		#1;
		chk("latch", 18'h00000, lat);
		chk("redir", 18'h00000, {10'h0, ra});
		stop_test();
	end
endmodule
`default_nettype wire
